// ### logic/lcd_ctrl_regs.svh
// Constants for the LCD supply, reset-default and frame-event control block
`ifndef LCD_CTRL_REGS_SVH
`define LCD_CTRL_REGS_SVH

// Supply-select encodings
`define SUP_INT_VLL2     2'h0
`define SUP_INT_VLL3     2'h1
`define SUP_EXT_VLCD     2'h2
`define SUP_EXT_BIAS     2'h3

// Reset values of the configuration fields
`define RST_DUTY         2'h3
`define RST_BIAS         2'h2
`define RST_FRAME_CLK    3'h0
`define RST_SUPPLY       2'h0
`define RST_BYPASS       1'h0
`define RST_BLINK        3'h0
`define RST_FP_EN        41'h0

// Frontplane count
`define FP_COUNT         41

// Pump settle time in timebase cycles
`define PUMP_SETTLE      5'h10
`define PUMP_CNT_ZERO    5'h00
`define PUMP_CNT_ONE     5'h01

// Frame timing in timebase cycles per sub-frame
`define FRAME_CNT_W      12
`define SUBFRAME_BASE    12'h010
`define FRAME_CNT_ZERO   12'h000
`define FRAME_CNT_ONE    12'h001

`endif

// ### logic/lcd_ctrl_pkg.sv
// Types shared by the LCD supply, reset-default and frame-event logic
`default_nettype none
package lcd_ctrl_pkg;

  // Software-written configuration fields
  typedef struct packed {
    logic [1:0]  supply_select;
    logic        buffer_bypass;
    logic        pump_enable;
    logic        pump_mode_select;
    logic [2:0]  frame_clock_select;
    logic [2:0]  blink_rate;
    logic        low_power_waveform;
    logic        frame_irq_enable;
    logic [40:0] frontplane_enable;
  } cfg_t;

  // Decoded supply and analog-control outputs
  typedef struct packed {
    logic power_switch_one;
    logic power_switch_two;
    logic power_switch_three;
    logic buffer_enable;
    logic divider_enable;
    logic vdd_supply;
    logic mid_bias_internal;
  } supply_t;

  // Frame sequencer state
  typedef enum logic [1:0] {
    FRM_FIRST  = 2'b01,
    FRM_SECOND = 2'b10
  } frame_state_t;

endpackage
`default_nettype wire

// ### logic/lcd_supply_decode.sv
// Combinational supply-select and pump decode for the LCD power path
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_regs.svh"
module lcd_supply_decode (
  input  wire logic [1:0]           supply_select_i,
  input  wire logic                 buffer_bypass_i,
  input  wire logic                 pump_enable_i,
  input  wire logic                 pump_mode_select_i,
  output lcd_ctrl_pkg::supply_t     sup_o
);

  // Switch map per supply source; 00 and 01 feed the module from VDD
  always_comb begin
    sup_o = '0;
    case (supply_select_i)
      `SUP_INT_VLL2: begin
        sup_o.power_switch_one = 1'b1;
        sup_o.vdd_supply       = 1'b1;
      end
      `SUP_INT_VLL3: begin
        sup_o.power_switch_two = 1'b1;
        sup_o.vdd_supply       = 1'b1;
      end
      `SUP_EXT_VLCD: begin
        sup_o.power_switch_three = 1'b1;
      end
      `SUP_EXT_BIAS: begin
        sup_o.power_switch_three = 1'b0;
      end
      default: begin
        sup_o.power_switch_three = 1'b0;
      end
    endcase
    // Buffer floats whenever bypassed or not on the external path
    sup_o.buffer_enable = ~buffer_bypass_i & sup_o.power_switch_three;
    // Doubler keeps the 2/3 divider in; tripler shorts it
    sup_o.divider_enable = ~pump_mode_select_i;
    sup_o.mid_bias_internal = pump_enable_i;
  end

endmodule // lcd_supply_decode
`default_nettype wire

// ### logic/lcd_supply_irq_reset_ctrl.sv
// Top of the LCD supply, reset-default and frame-event control block
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_regs.svh"
module lcd_supply_irq_reset_ctrl (
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  // Configuration write port: cfg_we_i loads every field at once
  input  wire logic                 cfg_we_i,
  input  wire lcd_ctrl_pkg::cfg_t   cfg_i,
  input  wire logic                 display_enable_we_i,
  input  wire logic                 display_enable_i,
  input  wire logic                 duty_we_i,
  input  wire logic [1:0]           duty_i,
  input  wire logic                 bias_we_i,
  input  wire logic [1:0]           bias_i,
  input  wire logic                 flag_write_i,
  input  wire logic                 flag_write_data_i,
  // State seen by software and the analog/waveform blocks
  output lcd_ctrl_pkg::cfg_t        cfg_o,
  output lcd_ctrl_pkg::supply_t     sup_o,
  output logic                      display_enable_o,
  output logic [1:0]                duty_o,
  output logic [1:0]                bias_o,
  output logic                      drivers_on_o,
  output logic [40:0]               frontplane_drive_o,
  output logic                      frame_event_flag_o,
  output logic                      lcd_irq_o,
  output logic                      subframe_o
);

  // Live configuration and helper nets
  lcd_ctrl_pkg::cfg_t               cfg;
  lcd_ctrl_pkg::supply_t            next_sup;
  lcd_ctrl_pkg::frame_state_t       frame_state;
  logic                             pump_prev;
  logic [4:0]                       pump_cnt;
  logic [`FRAME_CNT_W-1:0]          frame_cnt;
  logic [`FRAME_CNT_W-1:0]          subframe_len;
  logic                             event_pulse;
  logic                             pump_rise;
  logic                             next_drivers_on;

  // Sub-frame length grows by powers of two with the frame-clock select
  // (16 to 2048 cycles, so the shift never leaves the counter width)
  function automatic logic [`FRAME_CNT_W-1:0] len_of(input logic [2:0] sel);
    len_of = `FRAME_CNT_W'(`SUBFRAME_BASE << sel);
  endfunction

  // Supply and pump decode; registered below so outputs stay on flops
  lcd_supply_decode u_decode (
    .supply_select_i    (cfg.supply_select),
    .buffer_bypass_i    (cfg.buffer_bypass),
    .pump_enable_i      (cfg.pump_enable),
    .pump_mode_select_i (cfg.pump_mode_select),
    .sup_o              (next_sup)
  );

  // Configuration fields; reset brings back the defined defaults.
  // Pump-enable ordering is not left to software; the settle window below blocks the drivers.
  // Every field is loaded at once; there is no per-field write mask.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cfg                    <= '0;
      cfg.frame_clock_select <= `RST_FRAME_CLK;
      cfg.supply_select      <= `RST_SUPPLY;
      cfg.buffer_bypass      <= `RST_BYPASS;
      cfg.blink_rate         <= `RST_BLINK;
      cfg.frontplane_enable  <= `RST_FP_EN;
    end else if (cfg_we_i) begin
      cfg <= cfg_i;
    end
  end

  // Display enable, duty and bias
  // Duty code 3 is 1/4 multiplex and bias code 2 is 1/3 bias
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      display_enable_o <= 1'b0;
      duty_o           <= `RST_DUTY;
      bias_o           <= `RST_BIAS;
    end else begin
      if (display_enable_we_i) begin
        display_enable_o <= display_enable_i;
      end
      if (duty_we_i) begin
        duty_o <= duty_i;
      end
      if (bias_we_i) begin
        bias_o <= bias_i;
      end
    end
  end

  // Pump settle window: counts 16 cycles from the rising pump enable
  // Dropping and raising the pump again restarts the whole window
  assign pump_rise = cfg.pump_enable & ~pump_prev;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pump_prev <= 1'b0;
      pump_cnt  <= `PUMP_CNT_ZERO;
    end else begin
      pump_prev <= cfg.pump_enable;
      if (pump_rise) begin
        pump_cnt <= `PUMP_SETTLE;
      end else if (pump_cnt != `PUMP_CNT_ZERO) begin
        pump_cnt <= pump_cnt - `PUMP_CNT_ONE;
      end
    end
  end

  // Drivers are high impedance unless enabled and past the settle window
  // The rising pump edge itself blocks them, so no enabled cycle slips
  // through between the enable and the counter load
  assign next_drivers_on = display_enable_o & ~pump_rise
                         & (pump_cnt == `PUMP_CNT_ZERO);
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      drivers_on_o       <= 1'b0;
      frontplane_drive_o <= `RST_FP_EN;
    end else begin
      drivers_on_o       <= next_drivers_on;
      frontplane_drive_o <= next_drivers_on ?
                            cfg.frontplane_enable : `RST_FP_EN;
    end
  end

  // Registered supply decode, so outputs leave flip-flops
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sup_o <= '0;
    end else begin
      sup_o <= next_sup;
    end
  end

  // Software-visible copy, one cycle behind the live copy, so that it
  // lines up with the registered supply decode
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o <= cfg;
    end
  end

  // Frame sequencer: two equal sub-frames per frame; frame rate is the
  // same in both waveforms, only the event rate doubles in low power
  // Switching the display off parks the sequencer at the head of a frame
  assign subframe_len = len_of(cfg.frame_clock_select);
  assign event_pulse  = display_enable_o
                      & (frame_cnt == subframe_len - `FRAME_CNT_ONE)
                      & (cfg.low_power_waveform
                         | (frame_state == lcd_ctrl_pkg::FRM_SECOND));
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !display_enable_o) begin
      frame_cnt   <= `FRAME_CNT_ZERO;
      frame_state <= lcd_ctrl_pkg::FRM_FIRST;
      subframe_o  <= 1'b0;
    end else if (frame_cnt >= subframe_len - `FRAME_CNT_ONE) begin
      frame_cnt <= `FRAME_CNT_ZERO;
      case (frame_state)
        lcd_ctrl_pkg::FRM_FIRST: begin
          frame_state <= lcd_ctrl_pkg::FRM_SECOND;
          subframe_o  <= 1'b1;
        end
        lcd_ctrl_pkg::FRM_SECOND: begin
          frame_state <= lcd_ctrl_pkg::FRM_FIRST;
          subframe_o  <= 1'b0;
        end
        default: begin
          frame_state <= lcd_ctrl_pkg::FRM_FIRST;
          subframe_o  <= 1'b0;
        end
      endcase
    end else begin
      frame_cnt <= frame_cnt + `FRAME_CNT_ONE;
    end
  end

  // Sticky event flag, write-one-to-clear; a new event wins over the clear
  // Writing zero is ignored, so software can write back what it read
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      frame_event_flag_o <= 1'b0;
    end else if (event_pulse) begin
      frame_event_flag_o <= 1'b1;
    end else if (flag_write_i && flag_write_data_i) begin
      frame_event_flag_o <= 1'b0;
    end
  end

  // Interrupt follows flag and enable, one cycle behind the flag
  // Registered to keep every output on a flop, at one cycle of latency
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lcd_irq_o <= 1'b0;
    end else begin
      lcd_irq_o <= frame_event_flag_o & cfg.frame_irq_enable;
    end
  end

endmodule // lcd_supply_irq_reset_ctrl
`default_nettype wire

// ### tb/lcd_ctrl_props.sv
// Port-level assertions for the LCD supply and frame-event block
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_props (
  input wire logic                  clk_i,
  input wire logic                  rst_b_i,
  input wire logic                  flag_write_i,
  input wire logic                  flag_write_data_i,
  input wire lcd_ctrl_pkg::cfg_t    cfg_o,
  input wire lcd_ctrl_pkg::supply_t sup_o,
  input wire logic                  display_enable_o,
  input wire logic [1:0]            duty_o,
  input wire logic [1:0]            bias_o,
  input wire logic                  drivers_on_o,
  input wire logic [40:0]           frontplane_drive_o,
  input wire logic                  frame_event_flag_o,
  input wire logic                  lcd_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Skip the first edge after reset, where forced zeros still show
  sequence s_live; $past(rst_b_i); endsequence
  sequence s_ext; cfg_o.supply_select == 2'h2; endsequence
  sequence s_pump_up; $rose(cfg_o.pump_enable) ##2 1'b1; endsequence
  property p_ext; s_ext |-> sup_o[6:4] == 3'h1; endproperty
  property p_off; cfg_o.supply_select == 2'h3 |-> sup_o[6:4] == 3'h0;
  endproperty
  property p_buf; sup_o.buffer_enable == (!cfg_o.buffer_bypass &&
    sup_o.power_switch_three); endproperty
  property p_vdd; s_live ##0 !cfg_o.supply_select[1] |-> sup_o.vdd_supply;
  endproperty
  property p_pump; s_live |-> sup_o.divider_enable != cfg_o.pump_mode_select
    && sup_o.mid_bias_internal == cfg_o.pump_enable; endproperty
  property p_dflt; $rose(rst_b_i) |-> {duty_o, bias_o} == 4'he && cfg_o == '0
    && !display_enable_o && frontplane_drive_o == 41'h0; endproperty
  property p_hold; frame_event_flag_o && !(flag_write_i && flag_write_data_i)
    |=> frame_event_flag_o; endproperty
  property p_irq; frame_event_flag_o && cfg_o.frame_irq_enable ##1
    cfg_o.frame_irq_enable |-> lcd_irq_o; endproperty
  property p_quiet; !frame_event_flag_o |=> !lcd_irq_o; endproperty
  // Margin of two edges covers the pipeline ahead of the settle counter
  property p_settle; s_pump_up |-> !drivers_on_o [*8] ##1 !drivers_on_o [*7];
  endproperty
  a_ext:
    assert property (p_ext) else $error("external supply decode wrong");
  a_off:
    assert property (p_off) else $error("switch left on");
  a_buf:
    assert property (p_buf) else $error("buffer enable wrong");
  a_vdd:
    assert property (p_vdd) else $error("logic supply not chosen");
  a_pump:
    assert property (p_pump) else $error("pump decode wrong");
  a_dflt:
    assert property (p_dflt) else $error("reset default wrong");
  a_hold:
    assert property (p_hold) else $error("flag dropped");
  a_irq:
    assert property (p_irq) else $error("interrupt missing");
  a_quiet:
    assert property (p_quiet) else $error("interrupt without flag");
  a_settle:
    assert property (p_settle) else $error("drivers on during settle");
endmodule // lcd_ctrl_props
bind lcd_supply_irq_reset_ctrl lcd_ctrl_props u_props (.clk_i, .rst_b_i,
  .flag_write_i, .flag_write_data_i, .cfg_o, .sup_o, .display_enable_o,
  .duty_o, .bias_o, .drivers_on_o, .frontplane_drive_o, .frame_event_flag_o,
  .lcd_irq_o);
`default_nettype wire

// ### tb/lcd_panel_model.sv
// Behavioural glass model: counts frontplanes that are really driven
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  input  wire logic        clk_i,
  input  wire logic        drivers_on_i,
  input  wire logic [40:0] frontplane_i,
  output logic [5:0]       lit_o
);
  // Glass sees nothing while the drivers sit in high impedance
  always_ff @(posedge clk_i) begin
    lit_o <= drivers_on_i ? 6'($countones(frontplane_i)) : 6'h0;
  end
endmodule // lcd_panel_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the LCD supply, reset and frame-event block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tb;
  logic                  clk_i = 1'b0, rst_b_i = 1'b0, cfg_we_i = 1'b0;
  logic                  display_enable_we_i = 1'b0, display_enable_i = 1'b0;
  logic                  duty_we_i = 1'b0, bias_we_i = 1'b0;
  logic [1:0]            duty_i = 2'h0, bias_i = 2'h0, d;
  logic                  flag_write_i = 1'b0, flag_write_data_i = 1'b0;
  lcd_ctrl_pkg::cfg_t    cfg_i = '0, cfg_o, c;
  lcd_ctrl_pkg::supply_t sup_o, es;
  logic                  display_enable_o, drivers_on_o, lcd_irq_o;
  logic [1:0]            duty_o, bias_o;
  logic [40:0]           frontplane_drive_o;
  logic                  frame_event_flag_o, prev_flag = 1'b0;
  logic                  subframe_o, sub_prev = 1'b0;
  logic [5:0]            lit;
  int                    err_count = 0, n_tests = 0, cyc = 0, last = 0, e;
  int                    q[$];

  always #10 clk_i = ~clk_i;

  lcd_supply_irq_reset_ctrl DUT (.clk_i, .rst_b_i, .cfg_we_i, .cfg_i,
    .display_enable_we_i, .display_enable_i, .duty_we_i, .duty_i,
    .bias_we_i, .bias_i, .flag_write_i, .flag_write_data_i, .cfg_o, .sup_o,
    .display_enable_o, .duty_o, .bias_o, .drivers_on_o, .frontplane_drive_o,
    .frame_event_flag_o, .lcd_irq_o, .subframe_o);
  lcd_panel_model panel (.clk_i, .drivers_on_i(drivers_on_o),
    .frontplane_i(frontplane_drive_o), .lit_o(lit));

  task automatic finish_test();
    $display("checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Result side: a flag rise closes one interval noted by the driver when one is queued;
  // sampled on the falling edge, clear of the edge that moves the flag
  always @(negedge clk_i) begin
    cyc++;
    if (cyc > 40000) begin
      err_count++;
      finish_test();
    end
    if (frame_event_flag_o === 1'b1 && !prev_flag) begin
      if (q.size() > 0) begin
        e = q.pop_front();
        `CHK(cyc - last, e)
        `CHK(subframe_o, c.low_power_waveform ? ~sub_prev : 1'b0)
      end
      last = cyc;
      sub_prev = subframe_o;
    end
    prev_flag = frame_event_flag_o;
  end

  task automatic wcfg(input lcd_ctrl_pkg::cfg_t v);
    @(negedge clk_i);
    cfg_i = v;
    cfg_we_i = 1'b1;
    @(negedge clk_i);
    cfg_we_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask

  // One strobe task: 0 display, 1 duty, 2 bias, 3 event flag
  task automatic strobe(input int k, input logic [1:0] v);
    @(negedge clk_i);
    {display_enable_i, duty_i, bias_i, flag_write_data_i} = {v[0], v, v, v[0]};
    {display_enable_we_i, duty_we_i, bias_we_i, flag_write_i} = 4'h8 >> k;
    @(negedge clk_i);
    {display_enable_we_i, duty_we_i, bias_we_i, flag_write_i} = 4'h0;
  endtask

  task automatic chk_rst();
    `CHK({duty_o, bias_o}, 4'he)
    `CHK({display_enable_o, drivers_on_o}, 2'h0)
    `CHK(frontplane_drive_o, 41'h0)
    `CHK(cfg_o, lcd_ctrl_pkg::cfg_t'(0))
  endtask

  task automatic wait_on();
    for (int k = 0; k < 40 && drivers_on_o !== 1'b1; k++) @(negedge clk_i);
    repeat (2) @(negedge clk_i);
    `CHK(frontplane_drive_o, c.frontplane_enable)
    `CHK(lit, 6'($countones(c.frontplane_enable)))
  endtask

  // Waiting bound covers a counter wrapping after a long sub-frame
  task automatic rise_clear();
    for (int k = 0; k < 5000 && frame_event_flag_o !== 1'b1; k++)
      @(negedge clk_i);
    strobe(3, 2'h0);
    `CHK({frame_event_flag_o, lcd_irq_o}, {1'b1, c.frame_irq_enable})
    strobe(3, 2'h1);
    `CHK(frame_event_flag_o, 1'b0)
  endtask

  initial begin
    void'($urandom(32'h3198f694));
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    chk_rst();
    for (int i = 0; i < 3; i++) begin
      d = 2'($urandom);
      strobe(1, d);
      `CHK(duty_o, d)
      strobe(2, ~d);
      `CHK(bias_o, ~d)
    end
    // Display turned on first, then the pump: drivers must drop out
    c = 54'({$urandom, $urandom});
    c.pump_enable = 1'b0;
    wcfg(c);
    strobe(0, 2'h1);
    wait_on();
    c.pump_enable = 1'b1;
    wcfg(c);
    @(negedge clk_i);
    repeat (14) begin
      `CHK({drivers_on_o, frontplane_drive_o}, 42'h0)
      @(negedge clk_i);
    end
    wait_on();
    for (int i = 0; i < 8; i++) begin
      c = 54'({$urandom, $urandom});
      c.supply_select = 2'(i);
      if (!c.supply_select[1]) c.pump_enable = 1'b1;
      wcfg(c);
      es = {c.supply_select == 2'h0, c.supply_select == 2'h1,
            c.supply_select == 2'h2, 1'b0, !c.pump_mode_select,
            !c.supply_select[1], c.pump_enable};
      es.buffer_enable = es.power_switch_three && !c.buffer_bypass;
      `CHK(sup_o, es)
      `CHK(sup_o.mid_bias_internal, c.pump_enable)
    end
    // Normal, low-power, then a doubled sub-frame length
    for (int i = 0; i < 3; i++) begin
      c.low_power_waveform = (i == 1);
      c.frame_clock_select = 3'(i / 2);
      c.frame_irq_enable = (i != 1);
      wcfg(c);
      repeat (2) rise_clear();
      q.push_back((i == 1) ? 16 : 32 << (i / 2));
      rise_clear();
    end
    // Clear written onto the edge of the next event (64-cycle frame here):
    // the set must win and the flag stay up
    for (int k = 0; k < 5000 && frame_event_flag_o !== 1'b1; k++)
      @(negedge clk_i);
    repeat (62) @(negedge clk_i);
    strobe(3, 2'h1);
    `CHK(frame_event_flag_o, 1'b1)
    @(negedge clk_i);
    rst_b_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk_rst();
    rst_b_i = 1'b1;
    // Defaults must still stand two edges after the mid-run release
    repeat (2) @(negedge clk_i);
    chk_rst();
    finish_test();
  end
endmodule // tb
`default_nettype wire
